// ===== rtl/sdsa_pkg.sv
// Shared constants and types for the serial driver setting apply block
package sdsa_pkg;
  // ==========================================================================
  // Field layout of one lane setting word
  localparam int SDSA_SWING_LSB = 0;
  localparam int SDSA_SWING_W = 4;
  localparam int SDSA_POST_LSB = 8;
  localparam int SDSA_POST_W = 5;
  localparam int SDSA_PRE_LSB = 16;
  localparam int SDSA_PRE_W = 5;
  localparam int SDSA_WORD_W = 21;
  localparam int SDSA_CM_W = 3;
  localparam int SDSA_LANES = 8;
  localparam int SDSA_LANE_W = 3;
  localparam logic [4:0] SDSA_PRE_SAT = 5'h14;
  localparam logic [SDSA_WORD_W-1:0] SDSA_WORD_RST = 21'h000000;
  localparam logic [SDSA_CM_W-1:0] SDSA_CM_RST = 3'h0;
  // ==========================================================================
  // Timing
  localparam int SDSA_CLK_MHZ = 200;
  localparam int SDSA_PARK_US = 500;
  localparam int SDSA_PARK_CYC = SDSA_PARK_US * SDSA_CLK_MHZ;
  localparam int SDSA_RST_MS = 50;
  localparam int SDSA_RST_CYC = SDSA_RST_MS * 1000 * SDSA_CLK_MHZ;
  localparam int SDSA_CNT_W = 24;
  localparam int SDSA_CFG_CYC = 16;

  typedef enum logic [1:0]
  {
    SDSA_RUN = 2'b00,
    SDSA_PARKING = 2'b01,
    SDSA_PARKED = 2'b11
  } sdsa_state_e;

  // ==========================================================================
  // Saturating pre-emphasis coefficient
  function automatic logic [4:0] sdsa_pre_eff(input logic [4:0] code);
    sdsa_pre_eff = (code >= SDSA_PRE_SAT) ? SDSA_PRE_SAT : code;
  endfunction : sdsa_pre_eff
endpackage : sdsa_pkg

// ===== rtl/sdsa_if.sv
// Link between settings host and driver setting device
`timescale 1ns/1ps
interface sdsa_if;
  import sdsa_pkg::*;
  logic park_request_n;
  logic system_reset_n;
  logic wr_en;
  logic [SDSA_LANE_W-1:0] wr_lane;
  logic wr_cm;
  logic [SDSA_WORD_W-1:0] wr_data;
  logic cfg_done;
  logic parked;
  modport dev (input park_request_n, system_reset_n, wr_en, wr_lane, wr_cm, wr_data,
               output cfg_done, parked);
  modport host (output park_request_n, system_reset_n, wr_en, wr_lane, wr_cm, wr_data,
                input cfg_done, parked);
endinterface : sdsa_if

// ===== rtl/sdsa_device.sv
// Device end: shadow settings, park sequence and applied lane settings
`timescale 1ns/1ps
// Contract
// - Swing code in bits 3:0
// - Post-emphasis code in bits 12:8
// - Pre-emphasis bits 20:16, saturates at 20
// - Host picks matching receiver common-mode range
// - Host holds park low during power-up writes
// - Park release applies newly written settings
// - Park low stops link; host waits 500us
// - Host holds reset low 50ms while parked
// - Host writes settings before releasing park
// - Separate settings for four buses, four clocks
module sdsa_device
  import sdsa_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Link
  sdsa_if.dev link,
  // Applied driver settings, lanes 0-3 data, 4-7 clocks
  output logic [SDSA_LANES*SDSA_SWING_W-1:0] drive_swing_code_o,
  output logic [SDSA_LANES*SDSA_POST_W-1:0] post_emphasis_code_o,
  output logic [SDSA_LANES*SDSA_PRE_W-1:0] pre_emphasis_code_o,
  output logic [SDSA_CM_W-1:0] rx_cm_sel_o,
  output logic link_active_o,
  output logic apply_pulse_o
);
  // ==========================================================================
  // Local reset: either system reset or the link reset
  logic rst_n;
  assign rst_n = nrst_i & link.system_reset_n;

  logic [SDSA_WORD_W-1:0] shadow [SDSA_LANES];
  logic [SDSA_CM_W-1:0] shadow_cm;
  sdsa_state_e state;
  logic [SDSA_CNT_W-1:0] cnt;
  logic [4:0] cfg_cnt;
  logic park_q;

  // ==========================================================================
  // Configuration completes a fixed time after reset
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_cnt <= 5'h00;
      link.cfg_done <= 1'b0;
    end
    else if (!link.cfg_done)
    begin
      cfg_cnt <= cfg_cnt + 5'h01;
      link.cfg_done <= (cfg_cnt == 5'(SDSA_CFG_CYC - 1));
    end
  end

  // ==========================================================================
  // Shadow registers, written any time after configuration
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < SDSA_LANES; i++)
      begin
        shadow[i] <= SDSA_WORD_RST;
      end
      shadow_cm <= SDSA_CM_RST;
    end
    else if (link.wr_en && link.cfg_done)
    begin
      if (link.wr_cm)
      begin
        shadow_cm <= link.wr_data[SDSA_CM_W-1:0];
      end
      else
      begin
        shadow[link.wr_lane] <= link.wr_data;
      end
    end
  end

  // ==========================================================================
  // Release decode, shared by the sequencer and the applied settings
  function automatic logic sdsa_release(input sdsa_state_e st, input logic park_n,
                                        input logic park_prev, input logic cfg_ok);
    // A release before configuration is ignored until park toggles again
    sdsa_release = (st == SDSA_PARKED) && park_n && !park_prev && cfg_ok;
  endfunction : sdsa_release

  logic rel_go;
  logic park_go;
  logic park_done;
  assign rel_go = sdsa_release(state, link.park_request_n, park_q, link.cfg_done);
  assign park_go = (state == SDSA_RUN) && !link.park_request_n;
  // Parking finishes well inside the host's wait
  assign park_done = (state == SDSA_PARKING) && (cnt == SDSA_CNT_W'(SDSA_PARK_CYC / 2));

  // ==========================================================================
  // Park request history for the release edge
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Reset level matches the host's parked request, so no false edge
      park_q <= 1'b0;
    end
    else
    begin
      park_q <= link.park_request_n;
    end
  end

  // ==========================================================================
  // Park sequence: start parked, release applies settings
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= SDSA_PARKED;
    end
    else
    begin
      unique case (state)
        SDSA_RUN:
        begin
          if (park_go)
          begin
            state <= SDSA_PARKING;
          end
        end
        SDSA_PARKING:
        begin
          if (park_done)
          begin
            state <= SDSA_PARKED;
          end
        end
        SDSA_PARKED:
        begin
          if (rel_go)
          begin
            state <= SDSA_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Parking time counter
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
    end
    else if (park_go)
    begin
      cnt <= '0;
    end
    else if (state == SDSA_PARKING)
    begin
      cnt <= cnt + 24'h000001;
    end
  end

  // ==========================================================================
  // Parked status toward the host
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.parked <= 1'b1;
    end
    else if (park_done)
    begin
      link.parked <= 1'b1;
    end
    else if (rel_go)
    begin
      link.parked <= 1'b0;
    end
  end

  // ==========================================================================
  // Link activity stops as soon as parking starts
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_active_o <= 1'b0;
    end
    else if (park_go)
    begin
      link_active_o <= 1'b0;
    end
    else if (rel_go)
    begin
      link_active_o <= 1'b1;
    end
  end

  // ==========================================================================
  // Apply strobe, one cycle per release
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      apply_pulse_o <= 1'b0;
    end
    else
    begin
      apply_pulse_o <= rel_go;
    end
  end

  // ==========================================================================
  // Applied settings update only on release
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      drive_swing_code_o <= '0;
      post_emphasis_code_o <= '0;
      pre_emphasis_code_o <= '0;
      rx_cm_sel_o <= SDSA_CM_RST;
    end
    else if (rel_go)
    begin
      for (int i = 0; i < SDSA_LANES; i++)
      begin
        drive_swing_code_o[i*SDSA_SWING_W +: SDSA_SWING_W] <=
          shadow[i][SDSA_SWING_LSB +: SDSA_SWING_W];
        post_emphasis_code_o[i*SDSA_POST_W +: SDSA_POST_W] <=
          shadow[i][SDSA_POST_LSB +: SDSA_POST_W];
        pre_emphasis_code_o[i*SDSA_PRE_W +: SDSA_PRE_W] <=
          sdsa_pre_eff(shadow[i][SDSA_PRE_LSB +: SDSA_PRE_W]);
      end
      rx_cm_sel_o <= shadow_cm;
    end
  end
endmodule : sdsa_device

// ===== rtl/sdsa_host.sv
// Host end: runs power-up and run-time setting change sequences
`timescale 1ns/1ps
module sdsa_host
  import sdsa_pkg::*;
#(
  parameter int PARK_WAIT = SDSA_PARK_CYC,
  parameter int RST_HOLD = SDSA_RST_CYC
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Link
  sdsa_if.host link,
  // User side
  input wire logic start_i,
  input wire logic [SDSA_LANES*SDSA_WORD_W-1:0] lane_cfg_i,
  input wire logic [SDSA_CM_W-1:0] cm_sel_i,
  output logic busy_o
);
  typedef enum logic [2:0]
  {
    SDSA_H_IDLE = 3'b000,
    SDSA_H_PARKW = 3'b001,
    SDSA_H_RST = 3'b011,
    SDSA_H_CFGW = 3'b010,
    SDSA_H_WRITE = 3'b110,
    SDSA_H_REL = 3'b111
  } sdsa_hstate_e;

  sdsa_hstate_e hst;
  logic [SDSA_CNT_W-1:0] hcnt;
  logic [3:0] idx;

  // ==========================================================================
  // Power-up: park held low, then write and release
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hst <= SDSA_H_CFGW;
      hcnt <= '0;
      idx <= 4'h0;
      link.park_request_n <= 1'b0;
      link.system_reset_n <= 1'b1;
      link.wr_en <= 1'b0;
      link.wr_lane <= '0;
      link.wr_cm <= 1'b0;
      link.wr_data <= '0;
      busy_o <= 1'b1;
    end
    else
    begin
      link.wr_en <= 1'b0;
      unique case (hst)
        SDSA_H_IDLE:
        begin
          busy_o <= start_i;
          if (start_i)
          begin
            link.park_request_n <= 1'b0;
            hcnt <= '0;
            hst <= SDSA_H_PARKW;
          end
        end
        SDSA_H_PARKW:
        begin
          hcnt <= hcnt + 24'h000001;
          if (hcnt >= SDSA_CNT_W'(PARK_WAIT))
          begin
            link.system_reset_n <= 1'b0;
            hcnt <= '0;
            hst <= SDSA_H_RST;
          end
        end
        SDSA_H_RST:
        begin
          hcnt <= hcnt + 24'h000001;
          if (hcnt >= SDSA_CNT_W'(RST_HOLD))
          begin
            link.system_reset_n <= 1'b1;
            hst <= SDSA_H_CFGW;
          end
        end
        SDSA_H_CFGW:
        begin
          idx <= 4'h0;
          if (link.cfg_done)
          begin
            hst <= SDSA_H_WRITE;
          end
        end
        SDSA_H_WRITE:
        begin
          link.wr_en <= 1'b1;
          link.wr_cm <= (idx == 4'(SDSA_LANES));
          link.wr_lane <= idx[SDSA_LANE_W-1:0];
          // Common-mode code is the user's measured range
          link.wr_data <= (idx == 4'(SDSA_LANES)) ?
            {{(SDSA_WORD_W-SDSA_CM_W){1'b0}}, cm_sel_i} :
            lane_cfg_i[idx[SDSA_LANE_W-1:0]*SDSA_WORD_W +: SDSA_WORD_W];
          idx <= idx + 4'h1;
          if (idx == 4'(SDSA_LANES))
          begin
            hst <= SDSA_H_REL;
          end
        end
        SDSA_H_REL:
        begin
          link.park_request_n <= 1'b1;
          busy_o <= 1'b0;
          hst <= SDSA_H_IDLE;
        end
        default:
        begin
          hst <= SDSA_H_IDLE;
        end
      endcase
    end
  end
endmodule : sdsa_host

// ===== testbench/sdsa_properties.sv
// Checker for the park, reset and apply handshake on the link
`timescale 1ns/1ps
module sdsa_properties
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Link signals
  input wire logic park_request_n,
  input wire logic system_reset_n,
  input wire logic wr_en,
  input wire logic cfg_done,
  input wire logic parked
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ==========================================================================
  // Apply steps
  sequence s_release;
    $rose(park_request_n) && parked && cfg_done;
  endsequence
  sequence s_running;
    !parked ##1 !parked;
  endsequence
  a_apply_on_release: assert property (s_release |=> s_running)
    else $error("release did not leave park");
  a_leave_needs_release: assert property ($fell(parked) |->
    $past(park_request_n) && !$past(park_request_n, 2))
    else $error("park left without a release");
  a_write_needs_cfg: assert property (wr_en |-> cfg_done)
    else $error("write before config done");
  a_write_while_parked: assert property (wr_en |-> !park_request_n && parked)
    else $error("write while not parked");
  a_reset_only_parked: assert property (!system_reset_n |-> !park_request_n && parked)
    else $error("reset while not parked");
  a_reset_clears_cfg: assert property (!system_reset_n |=> !cfg_done)
    else $error("config done during reset");
  a_cfg_waits_reset: assert property ($rose(system_reset_n) |-> !cfg_done [*8])
    else $error("config done too early");
  a_parked_holds: assert property (parked && !park_request_n |=> parked)
    else $error("park lost while requested");
endmodule : sdsa_properties

// ===== testbench/serial_driver_setting_apply_tb.sv
// Bench joining host and device over the link
`timescale 1ns/1ps
module serial_driver_setting_apply_tb;
  import sdsa_pkg::*;
  // Park alone takes 50000 cycles; power-up is short
  localparam int LIMIT = 52000;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start_i = 1'b0;
  logic [167:0] lane_cfg_i = '0;
  logic [2:0] cm_sel_i = '0;
  logic busy_o;
  logic [31:0] swing_o;
  logic [39:0] post_o;
  logic [39:0] pre_o;
  logic [2:0] rx_cm_sel_o;
  logic link_active_o;
  logic apply_pulse_o;
  logic [111:0] outs;
  logic [31:0] seed = 32'h0000D7A8;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  assign outs = {pre_o, post_o, swing_o};
  always #2.5 ref_clk_i = ~ref_clk_i;
  // ==========================================================================
  // Design
  sdsa_if link ();
  sdsa_device sdsa_device_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(link),
    .drive_swing_code_o(swing_o), .post_emphasis_code_o(post_o), .pre_emphasis_code_o(pre_o),
    .rx_cm_sel_o(rx_cm_sel_o), .link_active_o(link_active_o), .apply_pulse_o(apply_pulse_o));
  sdsa_host #(.PARK_WAIT(50010), .RST_HOLD(60)) sdsa_host_i (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .link(link), .start_i(start_i), .lane_cfg_i(lane_cfg_i),
    .cm_sel_i(cm_sel_i), .busy_o(busy_o));
  sdsa_properties sdsa_properties_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .park_request_n(link.park_request_n), .system_reset_n(link.system_reset_n),
    .wr_en(link.wr_en), .cfg_done(link.cfg_done), .parked(link.parked));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  function automatic logic [167:0] rand_cfg();
    logic [167:0] c;
    logic [31:0] r;
    c = '0;
    for (int l = 0; l < 8; l++)
    begin
      r = xorshift();
      c[l*21 +: 21] = {r[20:16], 3'h0, r[12:8], 4'h0, r[3:0]};
    end
    return c;
  endfunction : rand_cfg
  function automatic logic [111:0] expect_out(input logic [167:0] c);
    logic [4:0] p;
    logic [111:0] e;
    e = '0;
    for (int l = 0; l < 8; l++)
    begin
      p = c[l*21+16 +: 5];
      e[l*4 +: 4] = c[l*21 +: 4];
      e[32+l*5 +: 5] = c[l*21+8 +: 5];
      e[72+l*5 +: 5] = (p > 5'h14) ? 5'h14 : p;
    end
    return e;
  endfunction : expect_out
  task automatic check(input string name, input logic [111:0] exp, input logic [111:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Loop is cut short by the cycle ceiling
  task automatic wait_apply(input string name, input logic [167:0] c, input logic [2:0] cm);
    logic [111:0] old;
    logic held;
    int age;
    old = outs;
    held = 1'b1;
    age = 0;
    while (apply_pulse_o !== 1'b1)
    begin
      @(negedge ref_clk_i);
      if (link.park_request_n === 1'b0)
        age++;
      if (age == 2)
        check("link_stopped", 112'h0, {111'h0, link_active_o});
      if (apply_pulse_o !== 1'b1 && outs !== old)
        held = 1'b0;
    end
    check("held_settings", 112'h1, {111'h0, held});
    check(name, expect_out(c), outs);
    check("cm_select", {109'h0, cm}, {109'h0, rx_cm_sel_o});
    check("link_up", 112'h1, {111'h0, link_active_o});
    check("host_idle", 112'h0, {111'h0, busy_o});
    @(negedge ref_clk_i);
    check("pulse_width", 112'h0, {111'h0, apply_pulse_o});
    $display("Test %s done", name);
  endtask : wait_apply
  // ==========================================================================
  // Sequence
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    logic [167:0] cfg;
    logic [31:0] r;
    cfg = rand_cfg();
    cfg[20:16] = 5'h1F;
    cfg[41:37] = 5'h14;
    cfg[62:58] = 5'h13;
    cfg[66:63] = 4'hF;
    cfg[75:71] = 5'h1F;
    repeat (20) @(posedge ref_clk_i);
    lane_cfg_i <= cfg;
    cm_sel_i <= 3'h7;
    nrst_i <= 1'b1;
    wait_apply("power_up", cfg, 3'h7);
    cfg = rand_cfg();
    r = xorshift();
    @(posedge ref_clk_i);
    lane_cfg_i <= cfg;
    cm_sel_i <= r[2:0];
    start_i <= 1'b1;
    while (busy_o !== 1'b1)
      @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    wait_apply("run_change", cfg, r[2:0]);
    finish_test();
  end
endmodule : serial_driver_setting_apply_tb
